// file: design/isam_pkg.sv
// shared constants and types of the i2c status flags and address mask block
package isam_pkg;
    // byte offsets on the register bus
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_MASK = 5'h04;
    localparam logic [4:0] OFF_TXBUF = 5'h08;
    localparam logic [4:0] OFF_RXBUF = 5'h0c;
    localparam logic [4:0] OFF_OWN = 5'h10;
    localparam logic [4:0] OFF_IRQST = 5'h14;
    localparam logic [4:0] OFF_IRQMSK = 5'h18;
    // status register bit positions
    localparam int B_TXFULL = 0;
    localparam int B_RXFULL = 1;
    localparam int B_DIR = 2;
    localparam int B_BEGIN = 3;
    localparam int B_HALT = 4;
    localparam int B_DATA = 5;
    localparam int B_OVF = 6;
    localparam int B_WCOL = 7;
    localparam int B_TEN = 8;
    // own address register: ten-bit mode select
    localparam int B_TENMODE = 15;
    // event bits of interrupt status and mask
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_RX = 2;
    localparam int EV_TXDONE = 3;
    localparam int EV_WCOL = 4;
    localparam int EV_OVF = 5;
    localparam int EV_W = 6;
    // widths, reset values and counts
    localparam int ADDR_W = 10;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] OWN_RST = 16'h0000;
    localparam logic [7:0] TX_IDLE = 8'hff;
    localparam logic [4:0] TEN_HDR = 5'h1e;
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    typedef enum logic [2:0] {S_IDLE, S_RECV, S_ACK, S_SEND, S_MACK} isam_state_t;
    typedef enum logic [1:0] {K_HDR, K_LOW, K_DATA} isam_kind_t;
endpackage

// file: design/isam_pin_sync.sv
// pin synchronisers and bus condition detection for scl and sda
`timescale 1ns/1ns
`default_nettype none
module isam_pin_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sclRise,
    output logic sclFall,
    output logic sdaLvl,
    output logic startDet,
    output logic stopDet
);
    logic sclMeta_ff;
    logic sclSync_ff;
    logic sclLast_ff;
    logic sdaMeta_ff;
    logic sdaSync_ff;
    logic sdaLast_ff;

    // two stages against metastability, third for edges; idle bus is high
    always_ff @(posedge clk) begin
        if (srst) begin
            sclMeta_ff <= 1'b1;
            sclSync_ff <= 1'b1;
            sclLast_ff <= 1'b1;
            sdaMeta_ff <= 1'b1;
            sdaSync_ff <= 1'b1;
            sdaLast_ff <= 1'b1;
        end else begin
            sclMeta_ff <= sclPin;
            sclSync_ff <= sclMeta_ff;
            sclLast_ff <= sclSync_ff;
            sdaMeta_ff <= sdaPin;
            sdaSync_ff <= sdaMeta_ff;
            sdaLast_ff <= sdaSync_ff;
        end
    end

    // sda moving while scl stays high marks start or stop
    assign sclRise = sclSync_ff & ~sclLast_ff;
    assign sclFall = ~sclSync_ff & sclLast_ff;
    assign sdaLvl = sdaSync_ff;
    assign startDet = sclSync_ff & sclLast_ff & sdaLast_ff & ~sdaSync_ff;
    assign stopDet = sclSync_ff & sclLast_ff & ~sdaLast_ff & sdaSync_ff;
endmodule
`default_nettype wire

// file: design/isam_addr_match.sv
// masked compare of an incoming slave address against the own address
`timescale 1ns/1ns
`default_nettype none
module isam_addr_match import isam_pkg::*; #(
    parameter int W = ADDR_W
) (
    input wire logic [W-1:0] candAddr,
    input wire logic [W-1:0] ownAddr,
    input wire logic [W-1:0] ignoreBits,
    output logic hit
);
    logic [W-1:0] bitOk;

    // a set ignore bit takes that position out of the compare
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign bitOk[i] = ignoreBits[i] | (candAddr[i] == ownAddr[i]);
        end
    endgenerate
    assign hit = &bitOk;
endmodule
`default_nettype wire

// file: design/isam_i2c_status.sv
// avalon register file, slave byte engine and status flags of the i2c block
`timescale 1ns/1ns
`default_nettype none
module isam_i2c_status import isam_pkg::*; #(
    parameter int AW = ADDR_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    // bus side
    logic waitRq_ff;
    logic [31:0] readData_ff;
    logic busReq;
    logic rdCommit;
    logic wrCommit;
    logic selStat;
    logic selMask;
    logic selTx;
    logic selRx;
    logic selOwn;
    logic selIrqSt;
    logic selIrqMsk;
    logic lane0;
    logic lane1;
    logic wrTx;
    logic wrTxOk;
    logic wrStat;
    logic rdRx;
    logic rdIrqSt;
    logic [31:0] rdMux;
    logic [15:0] statusWord;
    logic [15:0] maskWord;
    logic [15:0] ownWord;
    // software registers
    logic [AW-1:0] addressBitIgnore_ff;
    logic [AW-1:0] ownAddr_ff;
    logic tenMode_ff;
    logic [7:0] transmitBuffer_ff;
    logic [7:0] receiveBuffer_ff;
    logic [EV_W-1:0] irqStat_ff;
    logic [EV_W-1:0] irqMask_ff;
    logic [EV_W-1:0] nxt_irqStat;
    logic [EV_W-1:0] nxt_irqMask;
    logic [EV_W-1:0] evt;
    logic irq_ff;
    // status flags
    logic writeCollisionFlag_ff;
    logic receiveOverflowFlag_ff;
    logic receiveFullFlag_ff;
    logic transmitFullFlag_ff;
    logic tenBitMatchFlag_ff;
    logic dataKind_ff;
    logic haltFlag_ff;
    logic beginFlag_ff;
    logic dirRead_ff;
    // byte engine
    isam_state_t state_ff;
    isam_state_t nxt_state;
    isam_state_t afterAck_ff;
    isam_kind_t kind_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] rxSr_ff;
    logic [7:0] txSr_ff;
    logic [7:0] nxt_txSr;
    logic ackNow_ff;
    logic masterAck_ff;
    logic sdaOe_ff;
    logic sdaOut_ff;
    logic sclRise;
    logic sclFall;
    logic sdaLvl;
    logic startDet;
    logic stopDet;
    logic [7:0] rxByte;
    logic byteDone;
    logic isHdr;
    logic hit;
    logic [AW-1:0] candAddr;
    logic addrAck;
    logic lowAck;
    logic dataIn;
    logic loadRx;
    logic ovfEvt;
    logic ackIt;
    logic busy;
    logic wcolEvt;
    logic txDone;
    logic enterSend;

    isam_pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .sclPin(sclIn),
        .sdaPin(sdaIn),
        .sclRise(sclRise),
        .sclFall(sclFall),
        .sdaLvl(sdaLvl),
        .startDet(startDet),
        .stopDet(stopDet)
    );

    isam_addr_match #(.W(AW)) u_match (
        .candAddr(candAddr),
        .ownAddr(ownAddr_ff),
        .ignoreBits(addressBitIgnore_ff),
        .hit(hit)
    );

    // bus decode; a request commits on the edge that sees waitrequest low
    assign busReq = avs_read | avs_write;
    assign rdCommit = avs_read & ~waitRq_ff;
    assign wrCommit = avs_write & ~waitRq_ff;
    assign lane0 = avs_byteenable[0];
    assign lane1 = avs_byteenable[1];
    assign selStat = avs_address == OFF_STATUS;
    assign selMask = avs_address == OFF_MASK;
    assign selTx = avs_address == OFF_TXBUF;
    assign selRx = avs_address == OFF_RXBUF;
    assign selOwn = avs_address == OFF_OWN;
    assign selIrqSt = avs_address == OFF_IRQST;
    assign selIrqMsk = avs_address == OFF_IRQMSK;
    assign wrTx = wrCommit & selTx & lane0;
    assign wrStat = wrCommit & selStat & lane0;
    assign rdRx = rdCommit & selRx;
    assign rdIrqSt = rdCommit & selIrqSt;

    // collision window: buffer still occupied or a byte is on the wire
    assign busy = transmitFullFlag_ff | (state_ff == S_SEND);
    assign wrTxOk = wrTx & ~busy;
    assign wcolEvt = wrTx & busy;

    // read view; unimplemented bits read zero
    assign statusWord[B_TXFULL] = transmitFullFlag_ff;
    assign statusWord[B_RXFULL] = receiveFullFlag_ff;
    assign statusWord[B_DIR] = dirRead_ff;
    assign statusWord[B_BEGIN] = beginFlag_ff;
    assign statusWord[B_HALT] = haltFlag_ff;
    assign statusWord[B_DATA] = dataKind_ff;
    assign statusWord[B_OVF] = receiveOverflowFlag_ff;
    assign statusWord[B_WCOL] = writeCollisionFlag_ff;
    assign statusWord[B_TEN] = tenBitMatchFlag_ff;
    assign statusWord[15:B_TEN+1] = '0;
    assign maskWord = {{(16-AW){1'b0}}, addressBitIgnore_ff};
    assign ownWord = {tenMode_ff, {(15-AW){1'b0}}, ownAddr_ff};
    assign rdMux = selStat ? {16'h0000, statusWord} :
                   selMask ? {16'h0000, maskWord} :
                   selTx ? {24'h00_0000, transmitBuffer_ff} :
                   selRx ? {24'h00_0000, receiveBuffer_ff} :
                   selOwn ? {16'h0000, ownWord} :
                   selIrqSt ? {{(32-EV_W){1'b0}}, irqStat_ff} :
                   selIrqMsk ? {{(32-EV_W){1'b0}}, irqMask_ff} :
                   32'h0000_0000;

    // one wait cycle per access, data latched while waitrequest is high
    always_ff @(posedge clk) begin
        if (srst) begin
            waitRq_ff <= 1'b1;
            readData_ff <= 32'h0000_0000;
        end else begin
            waitRq_ff <= ~(busReq & waitRq_ff);
            if (busReq & waitRq_ff) begin
                readData_ff <= rdMux;
            end
        end
    end

    // mask and own address registers, with the ten-bit mode bit
    always_ff @(posedge clk) begin
        if (srst) begin
            addressBitIgnore_ff <= MASK_RST[AW-1:0];
            ownAddr_ff <= OWN_RST[AW-1:0];
            tenMode_ff <= OWN_RST[B_TENMODE];
        end else begin
            if (wrCommit & selMask & lane0) begin
                addressBitIgnore_ff[7:0] <= avs_writedata[7:0];
            end
            if (wrCommit & selMask & lane1) begin
                addressBitIgnore_ff[AW-1:8] <= avs_writedata[AW-1:8];
            end
            if (wrCommit & selOwn & lane0) begin
                ownAddr_ff[7:0] <= avs_writedata[7:0];
            end
            if (wrCommit & selOwn & lane1) begin
                ownAddr_ff[AW-1:8] <= avs_writedata[AW-1:8];
                tenMode_ff <= avs_writedata[B_TENMODE];
            end
        end
    end

    // events: sticky bits, a read of the interrupt status clears, a new event wins
    assign evt[EV_START] = startDet;
    assign evt[EV_STOP] = stopDet;
    assign evt[EV_RX] = loadRx;
    assign evt[EV_TXDONE] = txDone;
    assign evt[EV_WCOL] = wcolEvt;
    assign evt[EV_OVF] = ovfEvt;
    assign nxt_irqStat = (irqStat_ff & ~{EV_W{rdIrqSt}}) | evt;
    assign nxt_irqMask = (wrCommit & selIrqMsk & lane0) ? avs_writedata[EV_W-1:0] : irqMask_ff;

    // irq follows the next values so it never lags the visible status
    always_ff @(posedge clk) begin
        if (srst) begin
            irqStat_ff <= '0;
            irqMask_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            irqStat_ff <= nxt_irqStat;
            irqMask_ff <= nxt_irqMask;
            irq_ff <= |(nxt_irqStat & nxt_irqMask);
        end
    end

    // received byte and how the engine reads it
    assign rxByte = {rxSr_ff[6:0], sdaLvl};
    assign byteDone = sclRise & (state_ff == S_RECV) & (bitCnt_ff == BITS_LAST);
    assign isHdr = tenMode_ff & (rxByte[7:3] == TEN_HDR);
    assign candAddr = (kind_ff == K_LOW) ? {ownAddr_ff[AW-1:8], rxByte} :
                      isHdr ? {rxByte[2:1], ownAddr_ff[AW-3:0]} :
                      {ownAddr_ff[AW-1:7], rxByte[7:1]};
    // a ten-bit read header is only taken after the full address matched
    assign addrAck = byteDone & (kind_ff == K_HDR) & hit &
                     (~tenMode_ff | (isHdr & (~rxByte[0] | tenBitMatchFlag_ff)));
    assign lowAck = byteDone & (kind_ff == K_LOW) & hit;
    assign dataIn = byteDone & (kind_ff == K_DATA) & ~dirRead_ff;
    assign loadRx = dataIn & ~receiveFullFlag_ff;
    assign ovfEvt = dataIn & receiveFullFlag_ff;
    assign ackIt = addrAck | lowAck | loadRx;
    assign txDone = (state_ff == S_SEND) & sclFall & (bitCnt_ff == BITS_LAST);

    // byte engine sequencing; stop and start override any state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                nxt_state = S_IDLE;
            end
            S_RECV: begin
                if (sclFall && bitCnt_ff == BITS_BYTE) nxt_state = S_ACK;
            end
            S_ACK: begin
                if (sclFall) nxt_state = afterAck_ff;
            end
            S_SEND: begin
                if (txDone) nxt_state = S_MACK;
            end
            S_MACK: begin
                if (sclFall) nxt_state = masterAck_ff ? S_SEND : S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (startDet) nxt_state = S_RECV;
        if (stopDet) nxt_state = S_IDLE;
    end

    // an empty buffer sends all ones, which leaves sda released
    assign enterSend = (nxt_state == S_SEND) & (state_ff != S_SEND);
    assign nxt_txSr = enterSend ? (transmitFullFlag_ff ? transmitBuffer_ff : TX_IDLE) :
                      ((state_ff == S_SEND) & sclFall) ? {txSr_ff[6:0], 1'b1} :
                      txSr_ff;

    // state, bit counter and shift registers
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= S_IDLE;
            bitCnt_ff <= 4'h0;
            rxSr_ff <= 8'h00;
            txSr_ff <= TX_IDLE;
        end else begin
            state_ff <= nxt_state;
            txSr_ff <= nxt_txSr;
            if (startDet || nxt_state != state_ff) begin
                bitCnt_ff <= 4'h0;
            end else if ((state_ff == S_RECV && sclRise) || (state_ff == S_SEND && sclFall)) begin
                bitCnt_ff <= bitCnt_ff + 4'h1;
            end
            if (state_ff == S_RECV && sclRise) begin
                rxSr_ff <= rxByte;
            end
        end
    end

    // byte kind, acknowledge decision and master answer
    always_ff @(posedge clk) begin
        if (srst) begin
            kind_ff <= K_HDR;
            afterAck_ff <= S_IDLE;
            ackNow_ff <= 1'b0;
            masterAck_ff <= 1'b0;
        end else begin
            if (startDet) begin
                kind_ff <= K_HDR;
            end else if (addrAck) begin
                kind_ff <= (tenMode_ff & ~rxByte[0]) ? K_LOW : K_DATA;
            end else if (lowAck) begin
                kind_ff <= K_DATA;
            end
            if (byteDone) begin
                ackNow_ff <= ackIt;
                afterAck_ff <= ~ackIt ? S_IDLE : (addrAck & rxByte[0]) ? S_SEND : S_RECV;
            end
            if (state_ff == S_MACK && sclRise) begin
                masterAck_ff <= ~sdaLvl;
            end
        end
    end

    // open drain: only ever pulls low, enable set while driving
    always_ff @(posedge clk) begin
        if (srst) begin
            sdaOe_ff <= 1'b0;
            sdaOut_ff <= 1'b0;
        end else begin
            sdaOe_ff <= ((nxt_state == S_ACK) & ackNow_ff) | ((nxt_state == S_SEND) & ~nxt_txSr[7]);
            sdaOut_ff <= 1'b0;
        end
    end

    // bus condition and address flags
    always_ff @(posedge clk) begin
        if (srst) begin
            beginFlag_ff <= 1'b0;
            haltFlag_ff <= 1'b0;
            tenBitMatchFlag_ff <= 1'b0;
            dirRead_ff <= 1'b0;
            dataKind_ff <= 1'b0;
        end else begin
            if (stopDet) begin
                beginFlag_ff <= 1'b0;
                haltFlag_ff <= 1'b1;
            end else if (startDet) begin
                beginFlag_ff <= 1'b1;
                haltFlag_ff <= 1'b0;
            end
            if (stopDet) begin
                tenBitMatchFlag_ff <= 1'b0;
            end else if (lowAck) begin
                tenBitMatchFlag_ff <= 1'b1;
            end
            if (addrAck) begin
                dirRead_ff <= rxByte[0];
            end
            if (addrAck | lowAck) begin
                dataKind_ff <= 1'b0;
            end else if (dataIn) begin
                dataKind_ff <= 1'b1;
            end
        end
    end

    // buffers and their flags; a hardware set wins over a software clear
    always_ff @(posedge clk) begin
        if (srst) begin
            writeCollisionFlag_ff <= 1'b0;
            receiveOverflowFlag_ff <= 1'b0;
            receiveFullFlag_ff <= 1'b0;
            transmitFullFlag_ff <= 1'b0;
            transmitBuffer_ff <= 8'h00;
            receiveBuffer_ff <= 8'h00;
        end else begin
            writeCollisionFlag_ff <= (writeCollisionFlag_ff & ~(wrStat & ~avs_writedata[B_WCOL])) | wcolEvt;
            receiveOverflowFlag_ff <= (receiveOverflowFlag_ff & ~(wrStat & ~avs_writedata[B_OVF])) | ovfEvt;
            receiveFullFlag_ff <= (receiveFullFlag_ff & ~rdRx) | loadRx;
            transmitFullFlag_ff <= (transmitFullFlag_ff & ~txDone) | wrTxOk;
            if (wrTxOk) begin
                transmitBuffer_ff <= avs_writedata[7:0];
            end
            if (loadRx) begin
                receiveBuffer_ff <= rxByte; // overflow keeps the older byte
            end
        end
    end

    assign avs_readdata = readData_ff;
    assign avs_waitrequest = waitRq_ff;
    assign irq = irq_ff;
    assign sdaOut = sdaOut_ff;
    assign sdaOe = sdaOe_ff;

    // checks
    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);

    sequence busTake;
        busReq && waitRq_ff;
    endsequence
    sequence byteSent;
        (state_ff == S_SEND) && sclFall && (bitCnt_ff == BITS_LAST);
    endsequence
    sequence stopThenQuiet;
        stopDet ##1 !startDet;
    endsequence

    busAnswer_a: assert property (busTake |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus access not answered after one wait cycle");
    wcolSet_a: assert property (wcolEvt |=> writeCollisionFlag_ff && transmitBuffer_ff == $past(transmitBuffer_ff))
        else $error("busy transmit write not rejected");
    ovfSet_a: assert property (ovfEvt |=> receiveOverflowFlag_ff && receiveBuffer_ff == $past(receiveBuffer_ff))
        else $error("overflow not flagged or old byte lost");
    dataKind_a: assert property (dataIn |=> dataKind_ff)
        else $error("data byte not marked as data");
    beginSeen_a: assert property (startDet && !stopDet |=> beginFlag_ff && !haltFlag_ff)
        else $error("start not recorded");
    haltSeen_a: assert property (stopThenQuiet |-> haltFlag_ff && !beginFlag_ff && !tenBitMatchFlag_ff)
        else $error("stop not recorded");
    dirSet_a: assert property (addrAck |=> dirRead_ff == $past(sdaLvl))
        else $error("direction not taken from address byte");
    rxEmpty_a: assert property (rdRx && !loadRx |=> !receiveFullFlag_ff)
        else $error("receive full not cleared by read");
    txEmpty_a: assert property (byteSent |=> !transmitFullFlag_ff && state_ff == S_MACK)
        else $error("transmit full not cleared after byte");
    maskAll_a: assert property (byteDone && kind_ff == K_HDR && !tenMode_ff && (&addressBitIgnore_ff) |-> addrAck)
        else $error("fully masked address not accepted");
    maskRead_a: assert property (avs_read && !avs_waitrequest && selMask |-> avs_readdata[31:AW] == '0)
        else $error("unimplemented mask bits not zero");
    tenSet_a: assert property (lowAck |=> tenBitMatchFlag_ff)
        else $error("ten-bit match not flagged");
    irqLevel_a: assert property (irq == |(irqStat_ff & irqMask_ff))
        else $error("interrupt level disagrees with status and mask");
endmodule
`default_nettype wire

// file: verification/isam_i2c_master.sv
// behavioural i2c bus master facing the block
`timescale 1ns/1ns
`default_nettype none
module isam_i2c_master (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    // idle bus: both lines released, pulled high
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // data moves mid low phase so the slave never sees a false start
    task automatic bitx(input logic b, output logic r);
        #20 sdaLow = !b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
    endtask
    // start from idle: sda falls while scl is high
    task automatic startC();
        #20 sdaLow = 1'b1;
        #20 scl = 1'b0;
    endtask
    // stop, then the clock stands high between frames
    task automatic stopC();
        #20 sdaLow = 1'b1;
        #20 scl = 1'b1;
        #20 sdaLow = 1'b0;
        #40;
    endtask
    // byte msb first; nine is the ninth bit, 1 releases sda for the ack
    task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(nine, r);
        ack = !r;
        #20 sdaLow = 1'b0;
        #40;
    endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench: avalon master, i2c master model, read queue
`timescale 1ns/1ns
`default_nettype none
module testbench import isam_pkg::*;;
    typedef struct {string n; logic [31:0] v;} isam_exp_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, sdaOut, sdaOe, scl, mstLow, ack;
    logic [7:0] q, dat;
    logic [9:0] ownA, msk, cand;
    int errorCnt = 0;
    int compares = 0;
    int k;
    isam_exp_t expQ[$];
    isam_exp_t e;
    // open-drain sda with pull-up
    wire sdaWire = !mstLow & (sdaOe ? sdaOut : 1'b1);
    always #5 clk = !clk;
    isam_i2c_status dut_u (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe));
    isam_i2c_master mst_u (.scl(scl), .sdaLow(mstLow), .sda(sdaWire));
    task automatic conclude();
        $display("errors %0d compares %0d", errorCnt, compares);
        if (errorCnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    // one access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            errorCnt++;
            conclude();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [4:0] a, input logic [31:0] x);
        expQ.push_back('{n, x});
        acc(1'b0, a, 32'h0000_0000);
    endtask
    // address byte alone, then stop; ack must follow the masked compare
    task automatic probe(input logic [6:0] a, input logic x);
        mst_u.startC();
        mst_u.xfer({a, 1'b0}, 1'b1, q, ack);
        mst_u.stopC();
        chk("match", 32'(ack), 32'(x));
    endtask
    // each read answer meets the oldest noted expectation
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
            e = expQ.pop_front();
            chk(e.n, avs_readdata, e.v);
        end
    end
    // hang guard, set far above the length of the whole run
    initial begin
        #900000;
        errorCnt++;
        conclude();
    end
    initial begin
        void'($urandom(10));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd("status", OFF_STATUS, 32'h0000_0000);
        wr(OFF_MASK, 32'hffff_ffff);
        rd("mask", OFF_MASK, 32'h0000_03ff);
        rd("unmapped", 5'h1c, 32'h0000_0000);
        ownA = 10'($urandom()) & 10'h07f;
        dat = 8'($urandom());
        wr(OFF_OWN, {22'h00_0000, ownA});
        wr(OFF_MASK, 32'h0000_0000);
        wr(OFF_IRQMSK, 32'h0000_0004);
        mst_u.startC();
        rd("begin", OFF_STATUS, 32'h0000_0008);
        mst_u.xfer({ownA[6:0], 1'b0}, 1'b1, q, ack);
        rd("addr kind", OFF_STATUS, 32'h0000_0008);
        mst_u.xfer(dat, 1'b1, q, ack);
        chk("irq", 32'(irq), 32'h0000_0001);
        rd("rx full", OFF_STATUS, 32'h0000_002a);
        acc(1'b0, OFF_IRQST, 32'h0000_0000);
        @(posedge clk);
        chk("irq clear", 32'(irq), 32'h0000_0000);
        wr(OFF_IRQMSK, 32'h0000_0000);
        mst_u.xfer(~dat, 1'b1, q, ack);
        chk("ovf nack", 32'(ack), 32'h0000_0000);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        rd("overflow", OFF_STATUS, 32'h0000_006a);
        rd("rx buffer", OFF_RXBUF, {24'h00_0000, dat});
        rd("rx read", OFF_STATUS, 32'h0000_0068);
        wr(OFF_STATUS, 32'h0000_00bf);
        rd("ovf clear", OFF_STATUS, 32'h0000_0028);
        mst_u.stopC();
        rd("halt", OFF_STATUS, 32'h0000_0030);
        wr(OFF_TXBUF, {24'h00_0000, dat});
        rd("tx full", OFF_STATUS, 32'h0000_0031);
        wr(OFF_TXBUF, {24'h00_0000, ~dat});
        rd("collision", OFF_STATUS, 32'h0000_00b1);
        mst_u.startC();
        mst_u.xfer({ownA[6:0], 1'b1}, 1'b1, q, ack);
        mst_u.xfer(8'hff, 1'b1, q, ack);
        chk("read byte", {24'h00_0000, q}, {24'h00_0000, dat});
        rd("sent", OFF_STATUS, 32'h0000_008c);
        mst_u.stopC();
        // masked bits may differ, one unmasked bit may not
        for (int i = 0; i < 4; i++) begin
            k = $urandom_range(6);
            msk = 10'($urandom()) & ~(10'h001 << k);
            wr(OFF_MASK, {22'h00_0000, msk});
            cand = ownA ^ (10'($urandom()) & msk & 10'h07f);
            probe(cand[6:0], 1'b1);
            probe(cand[6:0] ^ (7'h01 << k), 1'b0);
        end
        conclude();
    end
endmodule
`default_nettype wire
